// ### include/vic_regs.vh
`ifndef VIC_REGS_VH
`define VIC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define VIC_OFS_CTRL0 12'h000
`define VIC_OFS_CTRL1 12'h004
`define VIC_OFS_CTRL2 12'h008
`define VIC_OFS_CTRL3 12'h00c
`define VIC_OFS_EDGE 12'h010

// ****************************************
// source indices, also priority (0 highest)
// ****************************************
`define VIC_NSRC 14
`define VIC_SRC_PIN0 0
`define VIC_SRC_PIN1 1
`define VIC_SRC_CMP0 2
`define VIC_SRC_CMP1 3
`define VIC_SRC_SERIAL 4
`define VIC_SRC_LOWV 5
`define VIC_SRC_ADC 6
`define VIC_SRC_EEPROM 7
`define VIC_SRC_PTMP 8
`define VIC_SRC_PTMA 9
`define VIC_SRC_STMP 10
`define VIC_SRC_STMA 11
`define VIC_SRC_TB0 12
`define VIC_SRC_TB1 13

// ****************************************
// vectors: base plus stride per source
// ****************************************
`define VIC_VEC_W 12
`define VIC_VEC_BASE 12'h004
`define VIC_VEC_STRIDE 12'h004

// ****************************************
// edge select codes and reset values
// ****************************************
`define VIC_EDGE_OFF 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3
`define VIC_RST_BYTE 8'h00
`define VIC_RST_SRC 14'h0000
`define VIC_RST_EDGE 4'h0
`define VIC_RST_WORD 32'h00000000
`define VIC_RST_PIN 2'h0
`define VIC_RST_IDX 4'h0

`endif

// ### core/vic_core.v
`timescale 1ns/100ps
`default_nettype none
`include "vic_regs.vh"

// Behaviour
// R1: source events set flags regardless of enables
// R2: disabled source keeps flag, no call
// R3: global enable low suppresses every call
// R4: core pushes return address, jumps to vector
// R5: return instruction pops saved address (core)
// R6: each source has its own vector
// R7: taking a call clears global enable
// R8: flags still latch while globally disabled
// R9: software re-enables global for nesting
// R10: no call while stack is full
// R11: fixed priority among simultaneous requests
// R12: any set flag raises wake
// R13: software presets flag to avoid wake; code raises wake for any set flag, a preset flag included
// R14: pin flag only on selected edge
// R15: pin needs enable, routing, input direction
// R16: pin call clears its own flag
// R17: rising, falling, both or disabled edges
// R18: edge codes 00 off 01 rise 10 fall 11 both
// R19: control zero layout, bit 7 zero
// R20: control one layout
// R21: control two layout
// R22: control three layout, bits 3,7 zero
// R23: all bits read/write, reset zero
// R24: other flags cleared on call too; code clears only the taken source's flag
// R25: pins synchronised, one-cycle edge pulses
module vic_core (
	input wire mclk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [1:0] extPin,
	input wire [1:0] pinRoutedToIrq,
	input wire [1:0] pinDirInput,
	input wire [`VIC_NSRC-1:0] srcEvent,
	input wire stackFull,
	input wire callTaken,
	output wire callRequest,
	output wire [`VIC_VEC_W-1:0] callVector,
	output wire wake
);

	// ****************************************
	// state
	// ****************************************
	reg emi_reg;
	reg [`VIC_NSRC-1:0] flag_reg;
	reg [`VIC_NSRC-1:0] enable_reg;
	reg [3:0] edge_reg;
	reg [1:0] pinSync1_reg;
	reg [1:0] pinSync2_reg;
	reg [1:0] pinPrev_reg;
	reg call_reg;
	reg [3:0] callIdx_reg;
	reg [`VIC_VEC_W-1:0] vector_reg;
	reg [31:0] rdata_reg;
	reg err_reg;

	wire wrAccess;
	wire setupPhase;
	wire [7:0] wbyte;
	wire [`VIC_NSRC-1:0] setEvent;
	wire [`VIC_NSRC-1:0] takenClear;
	wire [`VIC_NSRC-1:0] pending;
	wire [1:0] pinEdge;
	wire [7:0] ctrl0;
	wire [7:0] ctrl1;
	wire [7:0] ctrl2;
	wire [7:0] ctrl3;
	reg [`VIC_NSRC-1:0] flag_next;
	reg [`VIC_NSRC-1:0] enable_next;
	reg emi_next;
	reg [3:0] selIdx;
	reg selAny;
	reg [31:0] rdMux;
	reg rdErr;
	reg call_next;
	reg [3:0] callIdx_next;
	reg [`VIC_VEC_W-1:0] vector_next;
	wire accessPhase;
	wire callTake;
	wire hitCtrl0;
	wire hitCtrl1;
	wire hitCtrl2;
	wire hitCtrl3;
	wire hitEdge;
	integer i;

	// ****************************************
	// apb qualifiers and address decode
	// ****************************************
	assign accessPhase = psel & penable;
	assign wrAccess = accessPhase & pwrite;
	assign setupPhase = psel & ~penable;
	assign wbyte = pwdata[7:0];
	assign hitCtrl0 = (paddr == `VIC_OFS_CTRL0);
	assign hitCtrl1 = (paddr == `VIC_OFS_CTRL1);
	assign hitCtrl2 = (paddr == `VIC_OFS_CTRL2);
	assign hitCtrl3 = (paddr == `VIC_OFS_CTRL3);
	assign hitEdge = (paddr == `VIC_OFS_EDGE);
	assign callTake = callTaken & callRequest; //R7

	// ****************************************
	// register images
	// ****************************************
	assign ctrl0[7] = 1'b0; //R19
	assign ctrl0[6] = flag_reg[`VIC_SRC_PIN1];
	assign ctrl0[5] = flag_reg[`VIC_SRC_PIN0];
	assign ctrl0[4] = flag_reg[`VIC_SRC_CMP0];
	assign ctrl0[3] = enable_reg[`VIC_SRC_PIN1];
	assign ctrl0[2] = enable_reg[`VIC_SRC_PIN0];
	assign ctrl0[1] = enable_reg[`VIC_SRC_CMP0];
	assign ctrl0[0] = emi_reg;
	assign ctrl1[7] = flag_reg[`VIC_SRC_EEPROM]; //R20
	assign ctrl1[6] = flag_reg[`VIC_SRC_ADC];
	assign ctrl1[5] = flag_reg[`VIC_SRC_LOWV];
	assign ctrl1[4] = flag_reg[`VIC_SRC_SERIAL];
	assign ctrl1[3] = enable_reg[`VIC_SRC_EEPROM];
	assign ctrl1[2] = enable_reg[`VIC_SRC_ADC];
	assign ctrl1[1] = enable_reg[`VIC_SRC_LOWV];
	assign ctrl1[0] = enable_reg[`VIC_SRC_SERIAL];
	assign ctrl2[7] = flag_reg[`VIC_SRC_STMA]; //R21
	assign ctrl2[6] = flag_reg[`VIC_SRC_STMP];
	assign ctrl2[5] = flag_reg[`VIC_SRC_PTMA];
	assign ctrl2[4] = flag_reg[`VIC_SRC_PTMP];
	assign ctrl2[3] = enable_reg[`VIC_SRC_STMA];
	assign ctrl2[2] = enable_reg[`VIC_SRC_STMP];
	assign ctrl2[1] = enable_reg[`VIC_SRC_PTMA];
	assign ctrl2[0] = enable_reg[`VIC_SRC_PTMP];
	assign ctrl3[7] = 1'b0; //R22
	assign ctrl3[6] = flag_reg[`VIC_SRC_CMP1];
	assign ctrl3[5] = flag_reg[`VIC_SRC_TB1];
	assign ctrl3[4] = flag_reg[`VIC_SRC_TB0];
	assign ctrl3[3] = 1'b0;
	assign ctrl3[2] = enable_reg[`VIC_SRC_CMP1];
	assign ctrl3[1] = enable_reg[`VIC_SRC_TB1];
	assign ctrl3[0] = enable_reg[`VIC_SRC_TB0];

	// ****************************************
	// external pin edge detection
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinSync1_reg <= `VIC_RST_PIN;
			pinSync2_reg <= `VIC_RST_PIN;
		end else begin
			pinSync1_reg <= extPin; //R25
			pinSync2_reg <= pinSync1_reg;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinPrev_reg <= `VIC_RST_PIN;
		end else begin
			pinPrev_reg <= pinSync2_reg; //R25
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : pinEdgeGen
			wire [1:0] mode;
			wire rise;
			wire fall;
			wire modeRise;
			wire modeFall;
			wire modeBoth;
			assign mode = edge_reg[2*g+1:2*g];
			assign rise = pinSync2_reg[g] & ~pinPrev_reg[g]; //R25
			assign fall = ~pinSync2_reg[g] & pinPrev_reg[g];
			assign modeRise = (mode == `VIC_EDGE_RISE); //R18
			assign modeFall = (mode == `VIC_EDGE_FALL);
			assign modeBoth = (mode == `VIC_EDGE_BOTH);
			assign pinEdge[g] = pinRoutedToIrq[g] & pinDirInput[g] & //R15
				((modeRise & rise) | //R14
				(modeFall & fall) | //R17
				(modeBoth & (rise | fall)));
		end
	endgenerate

	// ****************************************
	// event sources and call clearing
	// ****************************************
	generate
		for (g = 0; g < `VIC_NSRC; g = g + 1) begin : srcGen
			if (g == `VIC_SRC_PIN0 || g == `VIC_SRC_PIN1) begin : pinSrc
				assign setEvent[g] = pinEdge[g]; //R14
			end else begin : intSrc
				assign setEvent[g] = srcEvent[g]; //R1
			end
			assign takenClear[g] = callTake & (callIdx_reg == g); //R16; clears only the taken source's flag, not the other flags of R24
			assign pending[g] = flag_reg[g] & enable_reg[g]; //R2
		end
	endgenerate

	// ****************************************
	// fixed priority select
	// ****************************************
	always @* begin
		selIdx = 4'h0;
		selAny = 1'b0;
		for (i = `VIC_NSRC - 1; i >= 0; i = i - 1) begin
			if (pending[i]) begin
				selIdx = i[3:0]; //R11
				selAny = 1'b1;
			end
		end
	end

	// ****************************************
	// software writes and flag update
	// ****************************************
	always @* begin
		flag_next = flag_reg & ~takenClear;
		enable_next = enable_reg;
		emi_next = emi_reg;
		if (callTake) begin
			emi_next = 1'b0; //R7
		end
		if (wrAccess) begin
			if (hitCtrl0) begin
				emi_next = wbyte[0]; //R23
				enable_next[`VIC_SRC_CMP0] = wbyte[1];
				enable_next[`VIC_SRC_PIN0] = wbyte[2];
				enable_next[`VIC_SRC_PIN1] = wbyte[3];
				flag_next[`VIC_SRC_CMP0] = wbyte[4]; //R13
				flag_next[`VIC_SRC_PIN0] = wbyte[5];
				flag_next[`VIC_SRC_PIN1] = wbyte[6];
			end else if (hitCtrl1) begin
				enable_next[`VIC_SRC_SERIAL] = wbyte[0];
				enable_next[`VIC_SRC_LOWV] = wbyte[1];
				enable_next[`VIC_SRC_ADC] = wbyte[2];
				enable_next[`VIC_SRC_EEPROM] = wbyte[3];
				flag_next[`VIC_SRC_SERIAL] = wbyte[4];
				flag_next[`VIC_SRC_LOWV] = wbyte[5];
				flag_next[`VIC_SRC_ADC] = wbyte[6];
				flag_next[`VIC_SRC_EEPROM] = wbyte[7];
			end else if (hitCtrl2) begin
				enable_next[`VIC_SRC_PTMP] = wbyte[0];
				enable_next[`VIC_SRC_PTMA] = wbyte[1];
				enable_next[`VIC_SRC_STMP] = wbyte[2];
				enable_next[`VIC_SRC_STMA] = wbyte[3];
				flag_next[`VIC_SRC_PTMP] = wbyte[4];
				flag_next[`VIC_SRC_PTMA] = wbyte[5];
				flag_next[`VIC_SRC_STMP] = wbyte[6];
				flag_next[`VIC_SRC_STMA] = wbyte[7];
			end else if (hitCtrl3) begin
				enable_next[`VIC_SRC_TB0] = wbyte[0];
				enable_next[`VIC_SRC_TB1] = wbyte[1];
				enable_next[`VIC_SRC_CMP1] = wbyte[2];
				flag_next[`VIC_SRC_TB0] = wbyte[4];
				flag_next[`VIC_SRC_TB1] = wbyte[5];
				flag_next[`VIC_SRC_CMP1] = wbyte[6];
			end
		end
		flag_next = flag_next | setEvent; //R8
	end

	// ****************************************
	// enable and flag state
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			emi_reg <= 1'b0;
		end else begin
			emi_reg <= emi_next;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= `VIC_RST_SRC;
		end else begin
			flag_reg <= flag_next; //R1
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= `VIC_RST_SRC;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// ****************************************
	// edge selection
	// ****************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge_reg <= `VIC_RST_EDGE;
		end else if (wrAccess & hitEdge) begin
			edge_reg <= wbyte[3:0]; //R17
		end
	end

	// ****************************************
	// call request to the core
	// ****************************************
	always @* begin
		call_next = 1'b0;
		callIdx_next = selIdx;
		vector_next = `VIC_VEC_BASE + `VIC_VEC_STRIDE * {8'h00, selIdx}; //R6
		if (emi_next & selAny & ~stackFull & ~callTake) begin
			call_next = 1'b1; //R3 R10
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			call_reg <= 1'b0;
			callIdx_reg <= `VIC_RST_IDX;
			vector_reg <= `VIC_VEC_BASE;
		end else begin
			call_reg <= call_next;
			callIdx_reg <= callIdx_next;
			vector_reg <= vector_next;
		end
	end

	assign callRequest = call_reg & emi_reg & ~stackFull; //R4 R5 R10
	assign callVector = vector_reg;
	assign wake = |flag_reg; //R12

	// ****************************************
	// apb read path
	// ****************************************
	always @* begin
		rdMux = `VIC_RST_WORD;
		rdErr = 1'b0;
		if (hitCtrl0) begin
			rdMux[7:0] = ctrl0;
		end else if (hitCtrl1) begin
			rdMux[7:0] = ctrl1;
		end else if (hitCtrl2) begin
			rdMux[7:0] = ctrl2;
		end else if (hitCtrl3) begin
			rdMux[7:0] = ctrl3;
		end else if (hitEdge) begin
			rdMux[3:0] = edge_reg;
		end else begin
			rdErr = 1'b1;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= `VIC_RST_WORD;
		end else if (setupPhase) begin
			rdata_reg <= rdMux;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			err_reg <= 1'b0;
		end else if (setupPhase) begin
			err_reg <= rdErr;
		end
	end

	assign prdata = rdata_reg;
	assign pready = 1'b1;
	assign pslverr = accessPhase & err_reg;

endmodule

`default_nettype wire

// ### testbench/vic_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "vic_regs.vh"
module vic_core_checker (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [`VIC_NSRC-1:0] srcEvent,
	input wire logic stackFull,
	input wire logic callTaken,
	input wire logic callRequest,
	input wire logic [`VIC_VEC_W-1:0] callVector,
	input wire logic wake
);
	// ****
	// port checks
	// ****
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable;
	rdy_const_a: assert property (pready) else $error("pready low");
	full_block_a: assert property (stackFull |-> !callRequest) else $error("call when full");
	take_clear_a: assert property (callRequest && callTaken |=> !callRequest)
		else $error("call after take");
	vec_align_a: assert property (callRequest |-> callVector[1:0] == 2'h0 &&
		callVector inside {[12'h004:12'h038]}) else $error("bad vector");
	wake_evt_a: assert property (|srcEvent[13:2] |=> wake) else $error("no wake");
	glob_off_a: assert property (acc && pwrite && paddr == 12'h000 && !pwdata[0]
		|=> !callRequest) else $error("call without global");
	bad_addr_a: assert property (acc && paddr > 12'h010 |-> pslverr) else $error("no slverr");
	hold_req_a: assert property (callRequest && !callTaken && !stackFull && !(acc && pwrite)
		|=> callRequest) else $error("call dropped");
	cover property (callRequest && callTaken);
	cover property (stackFull && wake);
	cover property (acc && pslverr);
endmodule
bind vic_core vic_core_checker chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .srcEvent(srcEvent), .stackFull(stackFull), .callTaken(callTaken),
	.callRequest(callRequest), .callVector(callVector), .wake(wake));
`default_nettype wire

// ### testbench/vic_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module vic_cpu_model #(
	parameter int DEPTH = 1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic callRequest,
	input wire logic retPulse,
	input wire logic slow,
	output logic callTaken,
	output logic stackFull
);
	// ****
	// core side of the call handshake
	// ****
	logic [3:0] depth_reg;
	logic wait_reg;
	assign stackFull = depth_reg == 4'(DEPTH);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			depth_reg <= 4'h0;
			wait_reg <= 1'b0;
			callTaken <= 1'b0;
		end else begin
			wait_reg <= callRequest && !callTaken && !wait_reg;
			callTaken <= callRequest && !callTaken && (!slow || wait_reg);
			depth_reg <= depth_reg + 4'(callTaken && callRequest) - 4'(retPulse);
		end
	end
endmodule
`default_nettype wire

// ### testbench/vectored_interrupt_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_controller_tb;
	logic mclk = 0, rst_n, psel = 0, penable = 0, pwrite = 0, retPulse = 0, slow = 0, e;
	logic stackFull, callTaken, callRequest, pready, pslverr, wake;
	logic [11:0] paddr = 0, callVector;
	logic [31:0] pwdata = 0, prdata, r;
	logic [1:0] extPin = 0, pinDir = 2'h3, pinRoute = 2'h3;
	logic [13:0] srcEvent = 0;
	int err_total = 0, check_count = 0;
	localparam int RA[14] = '{0, 0, 0, 12, 4, 4, 4, 4, 8, 8, 8, 8, 12, 12};
	localparam int RB[14] = '{5, 6, 4, 6, 4, 5, 6, 7, 4, 5, 6, 7, 4, 5};
	localparam logic [31:0] MSK[5] = '{32'h7e, 32'hff, 32'hff, 32'h77, 32'h0f};
	initial forever #20 mclk = ~mclk;
	vic_core dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extPin(extPin), .pinRoutedToIrq(pinRoute), .pinDirInput(pinDir), .srcEvent(srcEvent),
		.stackFull(stackFull), .callTaken(callTaken), .callRequest(callRequest),
		.callVector(callVector), .wake(wake));
	vic_cpu_model cpu_u (.mclk(mclk), .rst_n(rst_n), .callRequest(callRequest),
		.retPulse(retPulse), .slow(slow), .callTaken(callTaken), .stackFull(stackFull));
	// ****
	// tasks
	// ****
	task chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask
	task chkb(input logic g, input logic x);
		chk({31'h0, g}, {31'h0, x});
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task pulse();
		retPulse <= 1;
		@(posedge mclk);
		retPulse <= 0;
	endtask
	task take(input logic [31:0] v, input bit ret);
		int n;
		n = 0;
		while (callTaken !== 1'b1 && n++ < 20) @(posedge mclk);
		chkb(callTaken, 1);
		chk({20'h0, callVector}, v);
		if (ret) pulse();
	endtask
	task t_regs();
		for (int k = 0; k < 5; k++) begin
			apb(0, 12'(4 * k), 0);
			chk(r, 0);
			apb(1, 12'(4 * k), k ? 32'hff : 32'hfe);
			apb(0, 12'(4 * k), 0);
			chk(r, MSK[k]);
			apb(1, 12'(4 * k), 0);
		end
		apb(0, 12'h014, 0);
		chk(r, 0);
		chkb(e, 1);
	endtask
	task t_pins();
		for (int m = 0; m < 6; m++) begin
			pinDir <= {1'b1, m != 4};
			pinRoute <= {1'b1, m != 5};
			apb(1, 12'h010, m >= 4 ? 3 : m);
			extPin[0] <= 1;
			repeat (5) @(posedge mclk);
			apb(0, 12'h000, 0);
			chkb(r[5], m == 1 || m == 3);
			apb(1, 12'h000, 0);
			extPin[0] <= 0;
			repeat (5) @(posedge mclk);
			apb(0, 12'h000, 0);
			chkb(r[5], m == 2 || m == 3);
			apb(1, 12'h000, 0);
		end
		pinDir <= 2'h3;
		pinRoute <= 2'h3;
	endtask
	task t_prio();
		slow <= 1;
		apb(1, 12'h004, 32'h2);
		apb(1, 12'h00c, 32'h2);
		srcEvent <= 14'h2030;
		@(posedge mclk);
		srcEvent <= 0;
		@(posedge mclk);
		chkb(wake, 1);
		chkb(callRequest, 0);
		apb(1, 12'h000, 1);
		take(32'h18, 1);
		apb(1, 12'h000, 1);
		take(32'h38, 1);
		apb(0, 12'h004, 0);
		chk(r, 32'h12);
		apb(1, 12'h004, 0);
		apb(1, 12'h00c, 0);
		slow <= 0;
	endtask
	task t_call(input int i, input bit keep);
		int en;
		en = 1 << (RB[i] - (RA[i] == 0 ? 3 : 4));
		apb(1, 12'h010, 32'hf);
		apb(1, 12'(RA[i]), en);
		apb(1, 12'h000, RA[i] == 0 ? en | 1 : 1);
		if (i < 2) extPin[i] <= ~extPin[i];
		else srcEvent[i] <= 1;
		@(posedge mclk);
		srcEvent <= 0;
		if (stackFull) begin
			repeat (8) @(posedge mclk);
			chkb(callRequest, 0);
			pulse();
		end
		take(32'(4 + 4 * i), !keep);
		apb(0, 12'h000, 0);
		chkb(r[0], 0);
		apb(0, 12'(RA[i]), 0);
		chkb(r[RB[i]], 0);
		apb(1, 12'(RA[i]), 0);
	endtask
	task report_and_stop();
		if (err_total == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		rst_n = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		t_regs();
		t_pins();
		t_prio();
		for (int i = 0; i < 14; i++) t_call(i, 0);
		t_call(12, 1);
		t_call(13, 0);
		report_and_stop();
	end
	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
